/* File: hw/fsl_pkg.sv */
// Package: flash command codes, status bits, register map and timing counts
package fsl_pkg;
  // Device command data words
  localparam logic [15:0] CMD_STS_CFG_SETUP = 16'h00B8;
  localparam logic [15:0] CMD_LOCK_SETUP    = 16'h0060;
  localparam logic [15:0] CMD_LOCK_SET      = 16'h0001;
  localparam logic [15:0] CMD_LOCK_CLEAR    = 16'h00D0;
  localparam logic [15:0] CMD_READ_STATUS   = 16'h0070;
  localparam logic [15:0] CMD_CLEAR_STATUS  = 16'h0050;
  localparam logic [15:0] CMD_READ_INFO     = 16'h0090;
  localparam logic [15:0] CMD_READ_ARRAY    = 16'h00FF;
  // Lock state word sits at block base plus this offset
  localparam logic [23:0] LOCK_INFO_OFFSET  = 24'h000002;
  // Status register bit positions and the lock state word bit
  localparam int SR_READY_BIT    = 7;
  localparam int SR_CLRLOCK_BIT  = 5;
  localparam int SR_SETLOCK_BIT  = 4;
  localparam int LOCK_STATE_BIT  = 0;
  // Configuration code layout
  localparam int CFG_ERASE_BIT   = 0;
  localparam int CFG_PROG_BIT    = 1;
  localparam logic [7:0] CFG_LEVEL_MODE  = 8'h00;
  localparam logic [7:0] CFG_PROG_ONLY   = 8'h02;
  localparam logic [7:0] CFG_CODE_MASK   = 8'h03;
  // Controller register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_CFG    = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RESULT = 4'h4;
  // Control register command codes
  localparam logic [2:0] OP_NONE      = 3'h0;
  localparam logic [2:0] OP_STS_CFG   = 3'h1;
  localparam logic [2:0] OP_LOCK      = 3'h2;
  localparam logic [2:0] OP_UNLOCK    = 3'h3;
  localparam logic [2:0] OP_READ_LOCK = 3'h4;
  localparam logic [2:0] OP_CLR_STAT  = 3'h5;
  // Status register bits of the controller
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_ERR_BIT    = 1;
  localparam int ST_LOCKED_BIT = 2;
  localparam int ST_PULSE_BIT  = 3;
  localparam int ST_REFUSE_BIT = 4;
  // Bus timing
  localparam int CLK_PERIOD_NS   = 4;
  localparam int BUS_CYCLE_NS    = 80;
  localparam int BUS_CYCLES      =
    (BUS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MIN_NS    = 250;
  localparam int PULSE_MIN_CYC   =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_LIMIT      = 4000;
  localparam int CNT_W           = 12;
  typedef enum {
    ST_IDLE, ST_W1, ST_W2, ST_POLL, ST_RD_INFO, ST_RD_LOCK, ST_RD_ARRAY,
    ST_DONE
  } fsl_state_t;
endpackage

/* File: hw/fsl_bus_cycle.sv */
// One asynchronous flash bus cycle: write or read, fixed length
`timescale 1ns/10ps
module fsl_bus_cycle (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [15:0] dq_in_i,
  output logic             done_o,
  output logic [15:0]      rdata_o,
  output logic [23:0]      addr_o,
  output logic [15:0]      dq_out_o,
  output logic             dq_oe_o,
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             oe_n_o
);
  logic [fsl_pkg::CNT_W-1:0] cnt;
  logic                      active;
  logic                      is_wr;
  wire last = active && (cnt == fsl_pkg::CNT_W'(fsl_pkg::BUS_CYCLES - 1));

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt      <= '0;
      active   <= 1'b0;
      is_wr    <= 1'b0;
      done_o   <= 1'b0;
      rdata_o  <= 16'h0000;
      addr_o   <= 24'h000000;
      dq_out_o <= 16'h0000;
      dq_oe_o  <= 1'b0;
      ce_n_o   <= 1'b1;
      we_n_o   <= 1'b1;
      oe_n_o   <= 1'b1;
    end else begin
      done_o <= last;
      if (start_i && !active) begin
        active   <= 1'b1;
        cnt      <= '0;
        is_wr    <= write_i;
        addr_o   <= addr_i;
        dq_out_o <= wdata_i;
        dq_oe_o  <= write_i;
        ce_n_o   <= 1'b0;
        we_n_o   <= !write_i;
        oe_n_o   <= write_i;
      end else if (last) begin
        // Write data latched on the rising we edge; read sampled here
        active  <= 1'b0;
        ce_n_o  <= 1'b1;
        we_n_o  <= 1'b1;
        oe_n_o  <= 1'b1;
        dq_oe_o <= 1'b0;
        if (!is_wr) begin
          rdata_o <= dq_in_i;
        end
      end else if (active) begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule

/* File: hw/fsl_ctrl.sv */
// Host controller for flash status pin setup and block lock commands
//
// Contract
// - Configure pin: write 00B8h, then code, to any address.
// - Host configures pin only when device is ready, checked first.
// - Code bits 7 to 2 reserved and ignored.
// - Lock block: 0060h then 0001h to address in that block.
// - Unlock all: 0060h then 00D0h to any address.
// - Set-lock error in bit 4, clear-lock in bit 5; host clears.
// - Lock state read in info mode at block base plus 02h, bit 0.
`timescale 1ns/10ps
module fsl_ctrl (
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic [3:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic [31:0]      REG_RDATA_O,
  output logic [23:0]      FLASH_ADDR_O,
  input  wire logic [15:0] FLASH_DQ_I,
  output logic [15:0]      FLASH_DQ_O,
  output logic             FLASH_DQ_OE_O,
  output logic             FLASH_CE_N_O,
  output logic             FLASH_WE_N_O,
  output logic             FLASH_OE_N_O,
  output logic             FLASH_RESET_POWERDOWN_N_O,
  input  wire logic        STATUS_OUTPUT_PIN_I,
  output logic             COMPLETION_PULSE_O
);
  ////////////////////////////////////////////////////////////////////////
  // Software registers
  fsl_pkg::fsl_state_t     state;
  logic [2:0]              op;
  logic [23:0]             tgt_addr;
  logic [7:0]              cfg_code;
  logic [7:0]              pin_cfg;
  logic [7:0]              flash_status;
  logic                    err;
  logic                    refused;
  logic                    locked;
  logic                    pulse_seen;
  logic                    rp_n;
  logic [fsl_pkg::CNT_W-1:0] poll_cnt;
  logic [fsl_pkg::CNT_W-1:0] low_cnt;
  logic                    pin_q;

  wire wr_ctrl = REG_WR_I && (REG_ADDR_I == fsl_pkg::REG_CTRL);
  wire wr_addr = REG_WR_I && (REG_ADDR_I == fsl_pkg::REG_ADDR);
  wire wr_cfg  = REG_WR_I && (REG_ADDR_I == fsl_pkg::REG_CFG);
  wire [2:0] new_op = REG_WDATA_I[2:0];
  wire busy = (state != fsl_pkg::ST_IDLE);
  // Undefined op codes would fall through to a block lock, so drop them
  wire op_known = (new_op <= fsl_pkg::OP_CLR_STAT);
  wire start_op = wr_ctrl && !busy && op_known
                  && (new_op != fsl_pkg::OP_NONE);
  // Code 10 is refused here; reserved upper bits are masked off
  wire [7:0] cfg_eff = cfg_code & fsl_pkg::CFG_CODE_MASK;
  wire cfg_bad = (cfg_eff == fsl_pkg::CFG_PROG_ONLY);
  wire [31:0] status_word = {16'h0000, flash_status, 3'b000, refused,
    pulse_seen, locked, err, busy};
  wire [31:0] rd_mux =
    (REG_ADDR_I == fsl_pkg::REG_CTRL)   ? {29'h0, op} :
    (REG_ADDR_I == fsl_pkg::REG_ADDR)   ? {8'h00, tgt_addr} :
    (REG_ADDR_I == fsl_pkg::REG_CFG)    ? {24'h000000, cfg_code} :
    (REG_ADDR_I == fsl_pkg::REG_STATUS) ? status_word :
    (REG_ADDR_I == fsl_pkg::REG_RESULT) ? {16'h0000, flash_status, 8'h00} :
    32'h00000000;

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= 32'h00000000;
      tgt_addr    <= 24'h000000;
      cfg_code    <= fsl_pkg::CFG_LEVEL_MODE;
      rp_n        <= 1'b0;
    end else begin
      rp_n <= 1'b1;
      REG_RDATA_O <= REG_RD_I ? rd_mux : 32'h00000000;
      if (wr_addr) tgt_addr <= REG_WDATA_I[23:0];
      if (wr_cfg)  cfg_code <= REG_WDATA_I[7:0];
    end
  end

  // Reset pin held low during controller reset returns pin to level mode
  assign FLASH_RESET_POWERDOWN_N_O = rp_n;

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer
  logic        bc_start;
  logic        bc_write;
  logic [23:0] bc_addr;
  logic [15:0] bc_wdata;
  logic        bc_done;
  logic [15:0] bc_rdata;
  logic [15:0] first_word;
  logic [15:0] second_word;
  logic [23:0] second_addr;

  always_comb begin
    first_word  = fsl_pkg::CMD_LOCK_SETUP;
    second_word = fsl_pkg::CMD_LOCK_SET;
    second_addr = tgt_addr;
    case (op)
      fsl_pkg::OP_STS_CFG: begin
        first_word  = fsl_pkg::CMD_STS_CFG_SETUP;
        // Reserved bits always go out as zero
        second_word = {8'h00, cfg_eff};
      end
      fsl_pkg::OP_UNLOCK:   second_word = fsl_pkg::CMD_LOCK_CLEAR;
      fsl_pkg::OP_READ_LOCK: begin
        first_word  = fsl_pkg::CMD_READ_INFO;
        second_addr = tgt_addr + fsl_pkg::LOCK_INFO_OFFSET;
      end
      fsl_pkg::OP_CLR_STAT: first_word = fsl_pkg::CMD_CLEAR_STATUS;
      default: ;
    endcase
  end

  wire        st_w1   = (state == fsl_pkg::ST_W1);
  wire        st_w2   = (state == fsl_pkg::ST_W2);
  wire        st_rl   = (state == fsl_pkg::ST_RD_LOCK);
  assign bc_write = st_w1 || st_w2 || (state == fsl_pkg::ST_RD_INFO)
                    || (state == fsl_pkg::ST_RD_ARRAY);
  assign bc_addr  = st_w2 || st_rl ? second_addr : tgt_addr;
  assign bc_wdata = st_w2 ? second_word :
                    (state == fsl_pkg::ST_RD_INFO) ? fsl_pkg::CMD_READ_INFO :
                    (state == fsl_pkg::ST_RD_ARRAY) ? fsl_pkg::CMD_READ_ARRAY :
                    first_word;
  assign bc_start = busy && (state != fsl_pkg::ST_DONE) && !bc_done;
  // Device reports ready, so the read strobe returns status
  wire dev_ready = bc_rdata[fsl_pkg::SR_READY_BIT];
  wire dev_err = bc_rdata[fsl_pkg::SR_SETLOCK_BIT]
                 | bc_rdata[fsl_pkg::SR_CLRLOCK_BIT];
  wire poll_out = poll_cnt == fsl_pkg::CNT_W'(fsl_pkg::POLL_LIMIT);

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state        <= fsl_pkg::ST_IDLE;
      op           <= fsl_pkg::OP_NONE;
      flash_status <= 8'h00;
      err          <= 1'b0;
      refused      <= 1'b0;
      locked       <= 1'b0;
      poll_cnt     <= '0;
      pin_cfg      <= fsl_pkg::CFG_LEVEL_MODE;
    end else begin
      if (start_op) begin
        op       <= new_op;
        refused  <= 1'b0;
        err      <= 1'b0;
        poll_cnt <= '0;
        // Pin setup waits for a ready device; code 10 is not sent
        if (new_op == fsl_pkg::OP_STS_CFG && cfg_bad) begin
          refused <= 1'b1;
        end else begin
          state <= (new_op == fsl_pkg::OP_CLR_STAT) ? fsl_pkg::ST_W1
                   : fsl_pkg::ST_POLL;
        end
      end else if (bc_done) begin
        case (state)
          fsl_pkg::ST_POLL: begin
            flash_status <= bc_rdata[7:0];
            poll_cnt     <= poll_cnt + 1'b1;
            if (poll_out) begin
              err   <= 1'b1;
              state <= fsl_pkg::ST_DONE;
            end else if (dev_ready && op == fsl_pkg::OP_NONE) begin
              err   <= dev_err;
              state <= fsl_pkg::ST_DONE;
            end else if (dev_ready) begin
              state <= fsl_pkg::ST_W1;
            end
          end
          fsl_pkg::ST_W1: begin
            if (op == fsl_pkg::OP_CLR_STAT) begin
              state <= fsl_pkg::ST_DONE;
            end else begin
              // Lock setup leaves the device in status read mode
              state <= (op == fsl_pkg::OP_READ_LOCK) ? fsl_pkg::ST_RD_LOCK
                       : fsl_pkg::ST_W2;
            end
          end
          fsl_pkg::ST_W2: begin
            // Final poll until ready then check errors
            op       <= fsl_pkg::OP_NONE;
            if (op == fsl_pkg::OP_STS_CFG) begin
              pin_cfg <= cfg_eff;
            end
            poll_cnt <= '0;
            state    <= fsl_pkg::ST_POLL;
          end
          fsl_pkg::ST_RD_LOCK: begin
            locked <= bc_rdata[fsl_pkg::LOCK_STATE_BIT];
            state  <= fsl_pkg::ST_RD_ARRAY;
          end
          fsl_pkg::ST_RD_ARRAY: state <= fsl_pkg::ST_DONE;
          default: state <= fsl_pkg::ST_DONE;
        endcase
      end else if (state == fsl_pkg::ST_DONE) begin
        state <= fsl_pkg::ST_IDLE;
      end
    end
  end

  fsl_bus_cycle u_bus (
    .clk_i    (CLK_I),
    .reset_i  (RESET_I),
    .start_i  (bc_start),
    .write_i  (bc_write),
    .addr_i   (bc_addr),
    .wdata_i  (bc_wdata),
    .dq_in_i  (FLASH_DQ_I),
    .done_o   (bc_done),
    .rdata_o  (bc_rdata),
    .addr_o   (FLASH_ADDR_O),
    .dq_out_o (FLASH_DQ_O),
    .dq_oe_o  (FLASH_DQ_OE_O),
    .ce_n_o   (FLASH_CE_N_O),
    .we_n_o   (FLASH_WE_N_O),
    .oe_n_o   (FLASH_OE_N_O)
  );

  ////////////////////////////////////////////////////////////////////////
  // Completion pulse detector on the status pin
  // Counts a low span long enough to be a pulse, then reports once
  // Follows the code the device latched, not the staging register
  wire pulse_mode = (pin_cfg != fsl_pkg::CFG_LEVEL_MODE);
  wire pulse_hit = pulse_mode && !pin_q && STATUS_OUTPUT_PIN_I
    && (low_cnt >= fsl_pkg::CNT_W'(fsl_pkg::PULSE_MIN_CYC));

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pin_q              <= 1'b1;
      low_cnt            <= '0;
      pulse_seen         <= 1'b0;
      COMPLETION_PULSE_O <= 1'b0;
    end else begin
      pin_q              <= STATUS_OUTPUT_PIN_I;
      COMPLETION_PULSE_O <= pulse_hit;
      if (STATUS_OUTPUT_PIN_I) begin
        low_cnt <= '0;
      end else if (low_cnt != '1) begin
        low_cnt <= low_cnt + 1'b1;
      end
      // Set wins over the clear by a status register read
      if (pulse_hit) begin
        pulse_seen <= 1'b1;
      end else if (REG_RD_I && REG_ADDR_I == fsl_pkg::REG_STATUS) begin
        pulse_seen <= 1'b0;
      end
    end
  end
endmodule

/* File: verif/fsl_ctrl_monitor.sv */
// Port checker for the flash controller
`timescale 1ns/10ps
module fsl_ctrl_monitor (
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic [15:0] FLASH_DQ_O,
  input wire logic        FLASH_DQ_OE_O,
  input wire logic        FLASH_CE_N_O,
  input wire logic        FLASH_WE_N_O,
  input wire logic        FLASH_OE_N_O,
  input wire logic        FLASH_RESET_POWERDOWN_N_O,
  input wire logic        STATUS_OUTPUT_PIN_I,
  input wire logic        COMPLETION_PULSE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic [7:0] we_cnt;
  logic [7:0] low_cnt;
  logic [7:0] last_low;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      we_cnt   <= 8'h00;
      low_cnt  <= 8'h00;
      last_low <= 8'h00;
    end else begin
      we_cnt  <= FLASH_WE_N_O ? 8'h00 : we_cnt + 8'h01;
      low_cnt <= STATUS_OUTPUT_PIN_I ? 8'h00 : low_cnt + 8'h01;
      if (STATUS_OUTPUT_PIN_I && low_cnt != 8'h00)
        last_low <= low_cnt;
    end
  end
  sequence s_we_held;
    !FLASH_WE_N_O ##1 !FLASH_WE_N_O;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_rstpin_hold:
    assert property (!FLASH_RESET_POWERDOWN_N_O |-> $past(RESET_I)
      && FLASH_CE_N_O && FLASH_WE_N_O) else $error("reset pin late");
  chk_rstpin_free:
    assert property ($fell(RESET_I) |=> FLASH_RESET_POWERDOWN_N_O)
      else $error("reset pin stuck low");
  chk_write_frame:
    assert property (!FLASH_WE_N_O |-> !FLASH_CE_N_O && FLASH_OE_N_O
      && FLASH_DQ_OE_O) else $error("bad write framing");
  chk_read_frame:
    assert property (!FLASH_OE_N_O |-> !FLASH_CE_N_O && !FLASH_DQ_OE_O)
      else $error("bad read framing");
  chk_write_len:
    assert property ($rose(FLASH_WE_N_O) |-> we_cnt >= 8'h03
      && we_cnt <= fsl_pkg::BUS_CYCLES) else $error("bad write width");
  chk_data_hold:
    assert property (s_we_held |-> $stable(FLASH_DQ_O))
      else $error("data moved in write");
  chk_pulse_span:
    assert property ($rose(COMPLETION_PULSE_O) |->
      last_low >= fsl_pkg::PULSE_MIN_CYC) else $error("short pulse");
  chk_pulse_once:
    assert property (COMPLETION_PULSE_O |=> !COMPLETION_PULSE_O)
      else $error("long completion flag");
  chk_rdata_slot:
    assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
      else $error("read data out of slot");
endmodule

/* File: verif/fsl_flash_model.sv */
// Behavioural flash device: commands, lock bits, status output pin
`timescale 1ns/10ps
module fsl_flash_model #(
  parameter int BUSY  = 40,
  parameter int PULSE = 125
) (
  input  wire logic        clk_i,
  input  wire logic        rst_pin_n_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        program_enable_supply_ok_i,
  input  wire logic [1:0]  done_ev_i,
  output logic      [15:0] dq_o,
  output logic             pin_o
);
  logic        lk [256];
  logic [1:0]  cfg = 2'b00;
  logic        su_cfg, su_lock, info, we_d, e4, e5;
  logic [15:0] wd, last;
  logic [23:0] wa;
  int          busy = 0;
  int          pw = 0;
  wire         rd = !ce_n_i && !oe_n_i;
  wire  [15:0] stat = {8'h00, busy == 0, 1'b0, e5, e4, 4'h0};
  wire         hit = lk[addr_i[23:16]] && addr_i[15:0] == 16'h0002;
  wire  [15:0] val = info ? {15'h0000, hit} : stat;
  // Released bus shows the inverse, never a stale match
  assign dq_o = rd ? val : ~last;
  assign pin_o = cfg == 2'b00 ? busy == 0 : pw == 0;
  initial begin
    foreach (lk[i]) lk[i] = 1'b0;
    {su_cfg, su_lock, info, we_d, e4, e5, last} = '0;
  end
  always @(posedge clk_i) begin
    we_d <= we_n_i;
    if (rd) last <= val;
    if (!we_n_i) begin
      wa <= addr_i;
      wd <= dq_i;
    end
    if (busy > 0) busy <= busy - 1;
    if (pw > 0) pw <= pw - 1;
    if (|(done_ev_i & cfg)) pw <= PULSE;
    if (!rst_pin_n_i) begin
      cfg <= 2'b00;
      {su_cfg, su_lock, info, e4, e5} <= '0;
      busy <= 0;
    end else if (we_n_i && !we_d) begin
      su_cfg <= wd == 16'h00B8;
      su_lock <= wd == 16'h0060;
      if (su_cfg && wd[1:0] == 2'b10) {e5, e4} <= 2'b11;
      else if (su_cfg) cfg <= wd[1:0];
      else if (su_lock) begin
        busy <= BUSY;
        if (!program_enable_supply_ok_i || busy != 0) begin
          e4 <= wd == 16'h0001;
          e5 <= wd != 16'h0001;
        end else if (wd == 16'h0001) lk[wa[23:16]] <= 1'b1;
        else foreach (lk[i]) lk[i] <= 1'b0;
      end else if (wd == 16'h0090) info <= 1'b1;
      else if (wd == 16'h0050) {e5, e4} <= 2'b00;
      else info <= 1'b0;
    end
  end
endmodule

/* File: verif/fsl_ctrl_tb_top.sv */
// Bench: controller with flash model, checked against a bench model
`timescale 1ns/10ps
module fsl_ctrl_tb_top;
  localparam logic [3:0] ST = fsl_pkg::REG_STATUS;
  logic        clk, rst, wr, rd, program_enable_supply, dq_oe, ce_n, we_n, oe_n;
  logic        rst_pin_n, pin_lvl, cpl;
  logic [1:0]  ev, mcfg;
  logic [3:0]  ra;
  logic [31:0] wdat, rdat, v, seed;
  logic [23:0] fa;
  logic [15:0] dq_out, fl_dq;
  logic        exp_lk [256];
  int          q [$];
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  wire  [15:0] dq_bus = dq_oe ? dq_out : fl_dq;
  fsl_ctrl u_fsl_ctrl (.CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(ra),
    .REG_WDATA_I(wdat), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
    .FLASH_ADDR_O(fa), .FLASH_DQ_I(dq_bus), .FLASH_DQ_O(dq_out),
    .FLASH_DQ_OE_O(dq_oe), .FLASH_CE_N_O(ce_n), .FLASH_WE_N_O(we_n),
    .FLASH_OE_N_O(oe_n), .FLASH_RESET_POWERDOWN_N_O(rst_pin_n),
    .STATUS_OUTPUT_PIN_I(pin_lvl), .COMPLETION_PULSE_O(cpl));
  fsl_flash_model u_fsl_flash_model (.clk_i(clk), .rst_pin_n_i(rst_pin_n),
    .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fa),
    .dq_i(dq_bus), .program_enable_supply_ok_i(program_enable_supply), .done_ev_i(ev), .dq_o(fl_dq),
    .pin_o(pin_lvl));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      finish_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  // Poll bound covers the longest sequence with margin
  task automatic op(input logic [2:0] code);
    int n;
    n = 0;
    wreg(fsl_pkg::REG_CTRL, {29'h0, code});
    do begin
      rreg(ST);
      n++;
    end while (v[0] !== 1'b0 && n < 2000);
    chk(v[0], 1'b0);
  endtask
  task automatic lock(input logic [7:0] b, input logic [2:0] code);
    logic u;
    u = code == fsl_pkg::OP_UNLOCK;
    wreg(fsl_pkg::REG_ADDR, {8'h00, b, 16'h0000});
    op(code);
    chk(v[1], !program_enable_supply);
    chk(v[13:12], program_enable_supply ? 2'h0 : (u ? 2'h2 : 2'h1));
    chk(v[15], 1'b1);
    if (program_enable_supply && !u) exp_lk[b] = 1'b1;
    if (program_enable_supply && u) foreach (exp_lk[i]) exp_lk[i] = 1'b0;
  endtask
  task automatic vfy(input logic [7:0] b);
    wreg(fsl_pkg::REG_ADDR, {8'h00, b, 16'h0000});
    op(fsl_pkg::OP_READ_LOCK);
    chk(v[2], exp_lk[b]);
  endtask
  task automatic evt();
    for (int e = 1; e < 3; e++) begin
      @(posedge clk);
      ev <= e[1:0];
      @(posedge clk);
      ev <= 2'b00;
      repeat (20) @(posedge clk);
      // Pin level mid-pulse shows the mode the device really holds
      #1 chk(pin_lvl, !(|(mcfg & e[1:0])));
      repeat (180) @(posedge clk);
      rreg(ST);
      chk(v[3], |(mcfg & e[1:0]));
    end
  endtask
  task automatic pulse(input logic [7:0] c);
    wreg(fsl_pkg::REG_CFG, {24'h0, c});
    op(fsl_pkg::OP_STS_CFG);
    chk(v[4], c[1:0] == 2'b10);
    if (c[1:0] != 2'b10) mcfg = c[1:0];
    evt();
  endtask
  task automatic finish_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {wr, rd, ra, wdat, ev, mcfg} = '0;
    program_enable_supply = 1'b1;
    seed = 32'h00013DF1;
    foreach (exp_lk[i]) exp_lk[i] = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rreg(4'hF);
    chk(v, 32'h0);
    repeat (3) begin
      seed = xs(seed);
      q.push_back(seed[7:0]);
      lock(seed[7:0], fsl_pkg::OP_LOCK);
    end
    foreach (q[i]) vfy(q[i]);
    vfy(q[0] ^ 1);
    op(3'h7);
    vfy(q[0] ^ 1);
    pulse(8'hFD);
    pulse(8'h03);
    pulse(8'hFE);
    pulse(8'h00);
    pulse(8'h01);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mcfg = 2'b00;
    evt();
    foreach (q[i]) vfy(q[i]);
    program_enable_supply = 1'b0;
    lock(q[0] ^ 2, fsl_pkg::OP_LOCK);
    vfy(q[0] ^ 2);
    op(fsl_pkg::OP_CLR_STAT);
    program_enable_supply = 1'b1;
    lock(q[1], fsl_pkg::OP_UNLOCK);
    foreach (q[i]) vfy(q[i]);
    finish_test();
  end
endmodule
bind fsl_ctrl fsl_ctrl_monitor u_fsl_ctrl_monitor (.CLK_I, .RESET_I,
  .REG_RD_I, .REG_RDATA_O, .FLASH_DQ_O, .FLASH_DQ_OE_O, .FLASH_CE_N_O,
  .FLASH_WE_N_O, .FLASH_OE_N_O, .FLASH_RESET_POWERDOWN_N_O,
  .STATUS_OUTPUT_PIN_I, .COMPLETION_PULSE_O);
